// [shared/ccs_consts.svh]
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// Register indices; the byte address of each register is four times its index.
`define CCS_IDX_W 6
`define CCS_IDX_HSYNC_CTRL 6'h0E
`define CCS_IDX_CLAMP_COAST 6'h0F
`define CCS_IDX_CLK_CTRL 6'h15
`define CCS_IDX_CLAMP_TIMING 6'h20
`define CCS_IDX_PHASE 6'h21
`define CCS_IDX_STATUS 6'h22

// Field positions.
`define CCS_BIT_HSYNC_POL 6
`define CCS_BIT_EXT_CLAMP 7
`define CCS_BIT_CLAMP_POL 6
`define CCS_BIT_COAST_POL 3
`define CCS_BIT_EXT_CLK 0
`define CCS_LSB_CLAMP_DLY 0
`define CCS_LSB_CLAMP_DUR 8
`define CCS_BIT_MIDSCALE 16
`define CCS_LSB_PHASE 0

// Reset values.
`define CCS_RST_HSYNC_POL 1'b1
`define CCS_RST_EXT_CLAMP 1'b0
`define CCS_RST_CLAMP_POL 1'b1
`define CCS_RST_COAST_POL 1'b1
`define CCS_RST_EXT_CLK 1'b0
`define CCS_RST_MIDSCALE 1'b0
`define CCS_RST_CLAMP_DLY 8'h08
`define CCS_RST_CLAMP_DUR 8'h14
`define CCS_RST_PHASE 5'h00

// Conditioned pin slots.
`define CCS_NPIN 5
`define CCS_PIN_HSYNC 0
`define CCS_PIN_CLAMP 1
`define CCS_PIN_COAST 2
`define CCS_PIN_SYNC 3
`define CCS_PIN_INV 4

`endif

// [shared/ccs_pkg.sv]
package ccs_pkg;

    typedef enum logic [2:0] {
        CCS_IDLE = 3'h1,
        CCS_DELAY = 3'h2,
        CCS_ACTIVE = 3'h4
    } ccs_state_t;

    // Raw pin levels from outside the pixel clock domain.
    typedef struct packed {
        logic hsync;
        logic clamp;
        logic coast;
        logic embedded_sync_input;
        logic sample_clock_invert;
    } ccs_pins_t;

    // Controls towards the clock generator and sampling clock path.
    typedef struct packed {
        logic coast;
        logic lock_edge;
        logic use_alt_pixel_clock;
        logic [4:0] phase;
        logic sample_invert;
    } ccs_pll_ctl_t;

endpackage

// [rtl/ccs_pin_cond.sv]
`timescale 1ns/1ns
module ccs_pin_cond (
    input wire logic pclk, // Pixel clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic pin, // Raw asynchronous pin.
    input wire logic invert, // Polarity flip for the pin.
    output logic level, // Synchronised active-high level.
    output logic rise, // Active edge pulse.
    output logic fall // Inactive edge pulse.
);
    logic s1_q;
    logic s2_q;
    logic prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
        end
    end

    // Polarity is applied before edge detection so downstream is always active high.
    assign level = s2_q ^ invert;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

// [rtl/ccs_clamp_coast_ctrl.sv]
`timescale 1ns/1ns
`include "ccs_consts.svh"
// Contract
// - Embedded sync output is a non-inverted copy.
// - Clamp pin used only when external bit set.
// - Else clamp counted from hsync trailing edge.
// - Clamp polarity bit selects clamp pin level.
// - Clamp to ground or midscale while active.
// - Coast freezes generator frequency and phase.
// - Coast polarity bit selects coast pin level.
// - Coast polarity resets to one.
// - External clock bit selects alternate pixel clock.
// - Other functions, phase included, keep working.
// - Invert pin inverts the sampling clock.
// - Hsync polarity bit chooses active edge.
// - Leading edge for clock, trailing for clamp.
module ccs_clamp_coast_ctrl #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 8
) (
    input wire logic pclk, // Pixel clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable; low freezes all state.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire ccs_pkg::ccs_pins_t pins, // Raw timing pins.
    output logic embedded_sync_out, // Digital copy of the sync comparator.
    output logic clamp_active, // Clamp window.
    output logic clamp_midscale, // Clamp target: midscale when high.
    output ccs_pkg::ccs_pll_ctl_t pll_ctl // Clock generator controls.
);
    import ccs_pkg::*;

    localparam int IW = `CCS_IDX_W;

    logic hsync_pol_q;
    logic ext_clamp_q;
    logic clamp_pol_q;
    logic coast_pol_q;
    logic ext_clk_q;
    logic midscale_q;
    logic [CNT_W-1:0] clamp_dly_q;
    logic [CNT_W-1:0] clamp_dur_q;
    logic [4:0] phase_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    ccs_state_t state_q;
    ccs_state_t state_d;
    logic [31:0] rd_d;
    logic err_d;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [IW-1:0] idx;
    logic wr_en;
    logic [`CCS_NPIN-1:0] raw;
    logic [`CCS_NPIN-1:0] inv;
    logic [`CCS_NPIN-1:0] lvl;
    logic [`CCS_NPIN-1:0] rise;
    logic [`CCS_NPIN-1:0] fall;
    logic trail;
    logic lead;

    // Pin conditioning: two-stage synchroniser, polarity, edge detect.
    assign raw[`CCS_PIN_HSYNC] = pins.hsync;
    assign raw[`CCS_PIN_CLAMP] = pins.clamp;
    assign raw[`CCS_PIN_COAST] = pins.coast;
    assign raw[`CCS_PIN_SYNC] = pins.embedded_sync_input;
    assign raw[`CCS_PIN_INV] = pins.sample_clock_invert;

    assign inv[`CCS_PIN_HSYNC] = ~hsync_pol_q;
    assign inv[`CCS_PIN_CLAMP] = ~clamp_pol_q;
    assign inv[`CCS_PIN_COAST] = ~coast_pol_q;
    assign inv[`CCS_PIN_SYNC] = 1'b0;
    assign inv[`CCS_PIN_INV] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < `CCS_NPIN; gi = gi + 1) begin : g_pin
            ccs_pin_cond u_cond (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .pin(raw[gi]),
                .invert(inv[gi]),
                .level(lvl[gi]),
                .rise(rise[gi]),
                .fall(fall[gi])
            );
        end
    endgenerate

    assign lead = rise[`CCS_PIN_HSYNC];
    assign trail = fall[`CCS_PIN_HSYNC];

    // APB slave: zero wait states while enabled; read data captured in setup.
    assign idx = paddr[ADDR_W-1:2];
    assign pready = ce;
    assign wr_en = ce & psel & penable & pwrite;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            err_d = 1'b1;
        end else begin
            case (idx)
                `CCS_IDX_HSYNC_CTRL: begin
                    rd_d[`CCS_BIT_HSYNC_POL] = hsync_pol_q;
                end
                `CCS_IDX_CLAMP_COAST: begin
                    rd_d[`CCS_BIT_EXT_CLAMP] = ext_clamp_q;
                    rd_d[`CCS_BIT_CLAMP_POL] = clamp_pol_q;
                    rd_d[`CCS_BIT_COAST_POL] = coast_pol_q;
                end
                `CCS_IDX_CLK_CTRL: begin
                    rd_d[`CCS_BIT_EXT_CLK] = ext_clk_q;
                end
                `CCS_IDX_CLAMP_TIMING: begin
                    rd_d[`CCS_LSB_CLAMP_DLY +: CNT_W] = clamp_dly_q;
                    rd_d[`CCS_LSB_CLAMP_DUR +: CNT_W] = clamp_dur_q;
                    rd_d[`CCS_BIT_MIDSCALE] = midscale_q;
                end
                `CCS_IDX_PHASE: begin
                    rd_d[`CCS_LSB_PHASE +: 5] = phase_q;
                end
                `CCS_IDX_STATUS: begin
                    rd_d[0] = clamp_active;
                    rd_d[1] = pll_ctl.coast;
                    rd_d[2] = lvl[`CCS_PIN_HSYNC];
                    rd_d[3] = embedded_sync_out;
                    rd_d[4] = pll_ctl.sample_invert;
                    rd_d[7:5] = state_q;
                end
                default: begin
                    err_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce && psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr_q <= err_d;
        end
    end

    // Configuration registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsync_pol_q <= `CCS_RST_HSYNC_POL;
            ext_clamp_q <= `CCS_RST_EXT_CLAMP;
            clamp_pol_q <= `CCS_RST_CLAMP_POL;
            coast_pol_q <= `CCS_RST_COAST_POL;
            ext_clk_q <= `CCS_RST_EXT_CLK;
            midscale_q <= `CCS_RST_MIDSCALE;
            clamp_dly_q <= CNT_W'(`CCS_RST_CLAMP_DLY);
            clamp_dur_q <= CNT_W'(`CCS_RST_CLAMP_DUR);
            phase_q <= `CCS_RST_PHASE;
        end else if (wr_en && !err_d) begin
            case (idx)
                `CCS_IDX_HSYNC_CTRL: begin
                    hsync_pol_q <= pwdata[`CCS_BIT_HSYNC_POL];
                end
                `CCS_IDX_CLAMP_COAST: begin
                    ext_clamp_q <= pwdata[`CCS_BIT_EXT_CLAMP];
                    clamp_pol_q <= pwdata[`CCS_BIT_CLAMP_POL];
                    coast_pol_q <= pwdata[`CCS_BIT_COAST_POL];
                end
                `CCS_IDX_CLK_CTRL: begin
                    ext_clk_q <= pwdata[`CCS_BIT_EXT_CLK];
                end
                `CCS_IDX_CLAMP_TIMING: begin
                    clamp_dly_q <= pwdata[`CCS_LSB_CLAMP_DLY +: CNT_W];
                    clamp_dur_q <= pwdata[`CCS_LSB_CLAMP_DUR +: CNT_W];
                    midscale_q <= pwdata[`CCS_BIT_MIDSCALE];
                end
                `CCS_IDX_PHASE: begin
                    phase_q <= pwdata[`CCS_LSB_PHASE +: 5];
                end
                default: begin
                end
            endcase
        end
    end

    // Internal clamp timer; a new trailing edge always restarts it.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (trail) begin
            if (clamp_dly_q != '0) begin
                state_d = CCS_DELAY;
                cnt_d = clamp_dly_q - 1'b1;
            end else if (clamp_dur_q != '0) begin
                state_d = CCS_ACTIVE;
                cnt_d = clamp_dur_q - 1'b1;
            end else begin
                state_d = CCS_IDLE;
            end
        end else begin
            case (state_q)
                CCS_IDLE: begin
                end
                CCS_DELAY: begin
                    if (cnt_q != '0) begin
                        cnt_d = cnt_q - 1'b1;
                    end else if (clamp_dur_q != '0) begin
                        state_d = CCS_ACTIVE;
                        cnt_d = clamp_dur_q - 1'b1;
                    end else begin
                        state_d = CCS_IDLE;
                    end
                end
                CCS_ACTIVE: begin
                    if (cnt_q != '0) begin
                        cnt_d = cnt_q - 1'b1;
                    end else begin
                        state_d = CCS_IDLE;
                    end
                end
                default: begin
                    state_d = CCS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CCS_IDLE;
            cnt_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Clamp window output; the pin is ignored unless external clamping is on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamp_active <= 1'b0;
            clamp_midscale <= `CCS_RST_MIDSCALE;
        end else if (ce) begin
            clamp_active <= ext_clamp_q ? lvl[`CCS_PIN_CLAMP] : (state_q == CCS_ACTIVE);
            clamp_midscale <= midscale_q;
        end
    end

    // Sync copy and clock generator controls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            embedded_sync_out <= 1'b0;
            pll_ctl <= '0;
        end else if (ce) begin
            embedded_sync_out <= lvl[`CCS_PIN_SYNC];
            pll_ctl.coast <= lvl[`CCS_PIN_COAST];
            pll_ctl.lock_edge <= lead & ~lvl[`CCS_PIN_COAST];
            pll_ctl.use_alt_pixel_clock <= ext_clk_q;
            pll_ctl.phase <= phase_q;
            pll_ctl.sample_invert <= lvl[`CCS_PIN_INV];
        end
    end

    // Expected clamp window worked out from the raw pin and the polarity bit alone.
    function automatic logic clamp_expect(input logic raw_pin, input logic pol);
        return raw_pin ^ ~pol;
    endfunction

    sequence s_delay_two;
        trail && ce && !ext_clamp_q && clamp_dly_q == 8'h02 && clamp_dur_q != 8'h00;
    endsequence

    sequence s_quiet_two;
        (ce && !trail)[*2];
    endsequence

    AST_SOG_COPY: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> embedded_sync_out == $past(lvl[`CCS_PIN_SYNC]))
        else $error("Embedded sync output does not copy the comparator.");

    AST_EXT_CLAMP_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ext_clamp_q |=> clamp_active == $past(lvl[`CCS_PIN_CLAMP]))
        else $error("External clamp pin not followed.");

    AST_CLAMP_POL: assert property (@(posedge pclk) disable iff (!presetn)
        ce && $past(ce) && $past(ce, 2) && ext_clamp_q |=>
        clamp_active == clamp_expect($past(pins.clamp, 3), $past(clamp_pol_q)))
        else $error("Clamp polarity not applied.");

    AST_INT_IGNORES_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !ext_clamp_q |=> clamp_active == ($past(state_q) == CCS_ACTIVE))
        else $error("Internal clamp window does not follow the timer.");

    AST_CLAMP_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        s_delay_two ##1 s_quiet_two |=> state_q == CCS_ACTIVE)
        else $error("Clamp window did not open after the programmed delay.");

    AST_MIDSCALE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(clamp_active) |-> clamp_midscale == $past(midscale_q))
        else $error("Clamp target level wrong.");

    AST_COAST: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> pll_ctl.coast == $past(lvl[`CCS_PIN_COAST]))
        else $error("Coast output does not follow the coast pin.");

    AST_COAST_NO_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        pll_ctl.coast && $past(pll_ctl.coast) |-> !pll_ctl.lock_edge)
        else $error("Lock edge issued while coasting.");

    AST_COAST_POL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> coast_pol_q)
        else $error("Coast polarity not one after reset.");

    AST_EXT_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && idx == `CCS_IDX_CLK_CTRL && paddr[1:0] == 2'h0 |=> ##1
        pll_ctl.use_alt_pixel_clock == $past(pwdata[`CCS_BIT_EXT_CLK], 2) || !$past(ce))
        else $error("External clock select not applied.");

    AST_PHASE_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        ce && pll_ctl.use_alt_pixel_clock |=> pll_ctl.phase == $past(phase_q))
        else $error("Phase adjustment stopped with the external clock.");

    AST_INVERT: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> pll_ctl.sample_invert == $past(lvl[`CCS_PIN_INV]))
        else $error("Sampling clock inversion does not follow the pin.");

    AST_LEAD_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        ce && lead && !lvl[`CCS_PIN_COAST] |=> pll_ctl.lock_edge)
        else $error("Active hsync edge did not reach the clock generator.");
endmodule

// [rtl/unused_placeholder_none.sv]
`timescale 1ns/1ns

// [dv/ccs_source_model.sv]
`timescale 1ns/1ns
module ccs_source_model (
    input wire logic pclk, // Pixel clock.
    output ccs_pkg::ccs_pins_t pins // Raw timing pins towards the block.
);
    import ccs_pkg::*;

    // Unused clamp pin low and coast pin low, which is inactive with coast polarity 1.
    initial pins = '0;

    // One active-high sync pulse; returns on the edge that drives its end.
    task automatic hsync_pulse(input int width);
        @(posedge pclk);
        pins.hsync <= 1'b1;
        repeat (width) @(posedge pclk);
        pins.hsync <= 1'b0;
    endtask

    task automatic set_pin(input int sel, input logic v);
        @(posedge pclk);
        case (sel)
            1: pins.clamp <= v;
            2: pins.coast <= v;
            3: pins.embedded_sync_input <= v;
            default: pins.hsync <= v;
        endcase
    endtask

    // Inversion moves only inside a sync pulse, where no picture is being sampled.
    task automatic flip_invert();
        @(posedge pclk);
        pins.hsync <= 1'b1;
        @(posedge pclk);
        pins.sample_clock_invert <= ~pins.sample_clock_invert;
        repeat (4) @(posedge pclk);
        pins.hsync <= 1'b0;
    endtask
endmodule

// [dv/clamp_coast_clock_select_tb.sv]
`timescale 1ns/1ns
`include "ccs_consts.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module clamp_coast_clock_select_tb;
    import ccs_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic esync, clamp_act, clamp_mid, last_err;
    ccs_pins_t pins;
    ccs_pll_ctl_t pll;
    int failures, comparisons, lock_cnt, first, cnt;

    ccs_clamp_coast_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .embedded_sync_out(esync), .clamp_active(clamp_act), .clamp_midscale(clamp_mid),
        .pll_ctl(pll));
    ccs_source_model u_src (.pclk(pclk), .pins(pins));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) if (pll.lock_edge === 1'b1) lock_cnt <= lock_cnt + 1;

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [1:0] lo, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, idx, 2'b00, d);
    endtask

    task automatic rd(input logic [5:0] idx);
        apb(1'b0, idx, 2'b00, 32'h00000000);
    endtask

    // Lets the edge's updates land before anything is sampled.
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic end_test(input string name);
        $display("Test %s finished", name);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Window start is counted from the edge that drives the trailing edge of the sync pulse.
    // A window left running by an earlier sync edge is let run out first.
    task automatic clamp_window(input logic [7:0] dly, input logic [7:0] dur, input logic mid);
        settle(32);
        wr(`CCS_IDX_CLAMP_TIMING, {15'h0000, mid, dur, dly});
        u_src.hsync_pulse(6);
        first = 0;
        cnt = 0;
        for (int k = 1; k < 40; k++) begin
            @(posedge pclk);
            #1;
            if (clamp_act === 1'b1) begin
                cnt++;
                if (first == 0) first = k;
            end
        end
        `CHK("clamp length", dur, cnt[7:0])
        if (dur != 8'h00) `CHK("clamp start", 4 + dly, first)
        `CHK("clamp midscale", mid, clamp_mid)
    endtask

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        failures = 0;
        comparisons = 0;
        lock_cnt = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;

        rd(`CCS_IDX_HSYNC_CTRL);
        `CHK("hsync ctrl", 32'h00000040, rdat)
        rd(`CCS_IDX_CLAMP_COAST);
        `CHK("clamp coast ctrl", 32'h00000048, rdat)
        rd(`CCS_IDX_CLK_CTRL);
        `CHK("clock ctrl", 32'h00000000, rdat)
        rd(`CCS_IDX_CLAMP_TIMING);
        `CHK("clamp timing", 32'h00001408, rdat)
        wr(`CCS_IDX_STATUS, 32'hFFFFFFFF);
        rd(`CCS_IDX_STATUS);
        `CHK("status", 32'h00000020, rdat)
        apb(1'b1, `CCS_IDX_CLAMP_COAST, 2'b01, 32'h000000C8);
        `CHK("unaligned error", 1'b1, last_err)
        rd(6'h10);
        `CHK("unmapped error", 1'b1, last_err)
        rd(`CCS_IDX_CLAMP_COAST);
        `CHK("clamp coast kept", 32'h00000048, rdat)
        end_test("registers");

        for (int v = 1; v >= 0; v--) begin
            u_src.set_pin(3, v[0]);
            settle(5);
            `CHK("sync copy", v[0], esync)
        end
        @(posedge pclk);
        ce <= 1'b0;
        u_src.set_pin(3, 1'b1);
        settle(5);
        `CHK("frozen sync", 1'b0, esync)
        `CHK("pready held", 1'b0, pready)
        @(posedge pclk);
        ce <= 1'b1;
        settle(5);
        `CHK("thawed sync", 1'b1, esync)
        u_src.set_pin(3, 1'b0);
        settle(5);
        end_test("sync copy");

        for (int v = 0; v < 4; v++) begin
            if (v == 2) wr(`CCS_IDX_CLAMP_COAST, 32'h00000040);
            u_src.set_pin(2, v[0]);
            settle(5);
            `CHK("coast", v[0] ^ (v >= 2), pll.coast)
        end
        for (int p = 1; p >= 0; p--) begin
            wr(`CCS_IDX_HSYNC_CTRL, p << 6);
            settle(6);
            lock_cnt = 0;
            u_src.set_pin(0, 1'b1);
            settle(5);
            `CHK("lock on rise", p, lock_cnt)
            u_src.set_pin(0, 1'b0);
            settle(5);
            `CHK("lock per pulse", 1, lock_cnt)
        end
        wr(`CCS_IDX_HSYNC_CTRL, 32'h00000040);
        u_src.set_pin(2, 1'b0);
        settle(5);
        lock_cnt = 0;
        u_src.hsync_pulse(6);
        settle(6);
        `CHK("lock while coasting", 0, lock_cnt)
        wr(`CCS_IDX_CLAMP_COAST, 32'h00000048);
        settle(5);
        `CHK("coast released", 1'b0, pll.coast)
        end_test("coast and sync edges");

        clamp_window(8'h03, 8'h05, 1'b1);
        clamp_window(8'h00, 8'h02, 1'b0);
        clamp_window(8'h02, 8'h04, 1'b1);
        clamp_window(8'h02, 8'h00, 1'b0);
        u_src.set_pin(1, 1'b1);
        settle(8);
        `CHK("clamp pin ignored", 1'b0, clamp_act)
        wr(`CCS_IDX_CLAMP_COAST, 32'h000000C8);
        settle(5);
        `CHK("ext clamp high", 1'b1, clamp_act)
        wr(`CCS_IDX_CLAMP_COAST, 32'h00000088);
        settle(5);
        `CHK("ext clamp inverted", 1'b0, clamp_act)
        u_src.set_pin(1, 1'b0);
        settle(5);
        `CHK("ext clamp low active", 1'b1, clamp_act)
        wr(`CCS_IDX_CLAMP_COAST, 32'h00000048);
        end_test("clamp");

        wr(`CCS_IDX_CLK_CTRL, 32'h00000001);
        wr(`CCS_IDX_PHASE, 32'h00000013);
        settle(3);
        `CHK("alt clock", 1'b1, pll.use_alt_pixel_clock)
        `CHK("phase", 5'h13, pll.phase)
        wr(`CCS_IDX_CLK_CTRL, 32'h00000000);
        settle(3);
        `CHK("generated clock", 1'b0, pll.use_alt_pixel_clock)
        for (int v = 1; v >= 0; v--) begin
            u_src.flip_invert();
            settle(5);
            `CHK("sample invert", v[0], pll.sample_invert)
        end
        end_test("clock select");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        stop_test();
    end
endmodule
